// file: core/bdcu_pkg.sv
// bdcu_pkg: constants shared by the bus display command unit.
// assumes a 20 MHz core clock and a 50 kbit/s half-duplex serial line.
package bdcu_pkg;
	// clock and line rate
	localparam int CLK_HZ = 20000000;
	localparam int BAUD_KBPS = 50;
	localparam int BIT_CYCLES = CLK_HZ / (BAUD_KBPS * 1000);
	localparam int HALF_CYCLES = BIT_CYCLES / 2;
	// register numbers
	localparam logic [7:0] REG_DISPLAY = 8'h00;
	localparam logic [7:0] REG_DECIMAL = 8'h01;
	localparam logic [7:0] REG_POST_FIRST = 8'h0A;
	localparam logic [7:0] REG_POST_LAST = 8'h19;
	localparam int POST_COUNT = 16;
	// value limits and reset values
	localparam logic [15:0] DECIMAL_MAX = 16'h0005;
	localparam logic [15:0] DECIMAL_RESET = 16'h0000;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [4:0] ADDR_MIN = 5'h01;
	// command codes, first byte of a frame
	localparam logic [7:0] CMD_WRITE = 8'h50;
	localparam logic [7:0] CMD_READ = 8'h49;
	localparam logic [7:0] CMD_FLAG_SET = 8'h41;
	localparam logic [7:0] CMD_FLAG_CLR = 8'h43;
	localparam logic [7:0] CMD_FEEDBACK = 8'h46;
	// reply codes
	localparam logic [7:0] RSP_OK = 8'h06;
	localparam logic [7:0] RSP_ERROR = 8'h15;
	localparam logic [7:0] RSP_DATA = 8'h44;
	localparam logic [7:0] ERR_PREFIX = 8'h45;
	localparam logic [7:0] ASCII_DOT = 8'h2E;
	// error types
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_CHECKSUM = 8'h01;
	localparam logic [7:0] ERR_FRAMING = 8'h02;
	localparam logic [7:0] ERR_COMMAND = 8'h03;
	localparam logic [3:0] FRAME_ERR_LIMIT = 4'h3;
	// frame layout: cmd, addr, reg, val_hi, val_lo, line_hi, line_lo, checksum
	localparam int FRAME_BYTES = 8;
	localparam int ERR_REPLY_BYTES = 10;
	localparam int DATA_REPLY_BYTES = 4;
	localparam int FLAG_COUNT = 32;
	localparam logic [31:0] FLAG_RESET = 32'h0000_0080;
endpackage

// file: core/bdcu_uart_rx.sv
// bdcu_uart_rx: 8N1 receiver, one byte per valid pulse.
// assumes rxd already synchronised to clk.
`timescale 1ns/1ps
module bdcu_uart_rx #(
	parameter int BIT_CYC = bdcu_pkg::BIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// line
	input wire logic rxd,
	// byte out
	output logic [7:0] data_r,
	output logic valid_r,
	output logic frame_err_r
);
	initial begin
		if (BIT_CYC < 4) $error("bit period too short");
	end
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BREAK} bdcu_rx_t;
	bdcu_rx_t st_r;
	logic [15:0] cnt_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
	localparam logic [15:0] HALF = 16'(BIT_CYC / 2 - 1);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= RX_IDLE;
			cnt_r <= 16'h0000;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			data_r <= 8'h00;
			valid_r <= 1'b0;
			frame_err_r <= 1'b0;
		end else begin
			valid_r <= 1'b0;
			frame_err_r <= 1'b0;
			case (st_r)
				RX_IDLE: begin
					cnt_r <= HALF;
					if (!rxd) st_r <= RX_START;
				end
				RX_START: begin
					if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else if (rxd) begin
						frame_err_r <= 1'b1;
						st_r <= RX_IDLE;
					end else begin
						cnt_r <= FULL;
						bit_r <= 3'h0;
						st_r <= RX_DATA;
					end
				end
				RX_DATA: begin
					if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else begin
						sh_r <= {rxd, sh_r[7:1]};
						cnt_r <= FULL;
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) st_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (cnt_r != 16'h0000) begin
						cnt_r <= cnt_r - 16'h0001;
					end else begin
						if (rxd) begin
							st_r <= RX_IDLE;
							data_r <= sh_r;
							valid_r <= 1'b1;
						end else begin
							// line still low: wait for idle so one fault is counted once
							st_r <= RX_BREAK;
							frame_err_r <= 1'b1;
						end
					end
				end
				RX_BREAK: begin
					if (rxd) st_r <= RX_IDLE;
				end
				default: st_r <= RX_IDLE;
			endcase
		end
	end
	chk_rx_pulse_excl: assert property (@(posedge clk) disable iff (rst)
		!(valid_r && frame_err_r)) else $error("valid and framing fault together");
endmodule

// file: core/bdcu_uart_tx.sv
// bdcu_uart_tx: 8N1 transmitter with ready flag.
// assumes start is pulsed only while ready_r is high.
`timescale 1ns/1ps
module bdcu_uart_tx #(
	parameter int BIT_CYC = bdcu_pkg::BIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// byte in
	input wire logic start,
	input wire logic [7:0] data,
	output logic ready_r,
	// line
	output logic txd_r
);
	initial begin
		if (BIT_CYC < 4) $error("bit period too short");
	end
	localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
	logic [15:0] cnt_r;
	logic [3:0] bit_r;
	logic [9:0] sh_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 16'h0000;
			bit_r <= 4'h0;
			sh_r <= 10'h3FF;
			ready_r <= 1'b1;
			txd_r <= 1'b1;
		end else if (ready_r) begin
			if (start) begin
				sh_r <= {1'b1, data, 1'b0};
				ready_r <= 1'b0;
				cnt_r <= FULL;
				bit_r <= 4'h0;
				txd_r <= 1'b0;
			end
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else if (bit_r == 4'h9) begin
			ready_r <= 1'b1;
			txd_r <= 1'b1;
		end else begin
			bit_r <= bit_r + 4'h1;
			cnt_r <= FULL;
			txd_r <= sh_r[bit_r + 4'h1];
		end
	end
	chk_tx_start_bit: assert property (@(posedge clk) disable iff (rst)
		ready_r && start |=> !txd_r && !ready_r) else $error("start bit missing");
endmodule

// file: core/bdcu_top.sv
// bdcu_top: command interpreter of a bus display module.
// assumes an RS485 transceiver on rxd/txd/tx_en and address switches on addr_sw.
// Summary of operation
// - five-digit display shows display register value
// - write to register zero updates shown value
// - decimal register resets to zero, no point
// - decimal register accepts zero to five only
// - sixteen postboxes store values, display untouched
// - bad command answered with error, not executed
// - feedback query answered with stored error report
// - report: prefix, type, address, line, dot-separated
// - checksum mismatch reports error type one
// - repeated framing faults report error type two
// - unknown command or register reports type three
// - address from switches, respond only when matched
// - write carries address, register, value; loads it
// - flag set and clear commands change flags
`timescale 1ns/1ps
module bdcu_top #(
	parameter int BIT_CYC = bdcu_pkg::BIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial line
	input wire logic rxd,
	output logic txd_r,
	output logic tx_en_r,
	// address switches
	input wire logic [4:0] addr_sw,
	// display side
	output logic [15:0] display_value_r,
	output logic [2:0] decimal_places_r,
	output logic [31:0] flags_r
);
	initial begin
		if (BIT_CYC < 4) $error("bit period too short");
	end
	typedef enum logic [2:0] {
		BD_COLLECT, BD_EXEC, BD_REPLY, BD_WAIT
	} bdcu_state_t;
	// input synchronisers
	logic rxd_m_r, rxd_s_r;
	logic [4:0] sw_m_r, sw_s_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxd_m_r <= 1'b1;
			rxd_s_r <= 1'b1;
			sw_m_r <= 5'h00;
			sw_s_r <= 5'h00;
		end else begin
			rxd_m_r <= rxd;
			rxd_s_r <= rxd_m_r;
			sw_m_r <= addr_sw;
			sw_s_r <= sw_m_r;
		end
	end
	// receiver and transmitter
	logic [7:0] rx_data;
	logic rx_valid, rx_ferr, tx_ready, tx_start_r;
	logic [7:0] tx_byte_r;
	logic tx_line;
	bdcu_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
		.clk(clk),
		.rst(rst),
		.rxd(rxd_s_r),
		.data_r(rx_data),
		.valid_r(rx_valid),
		.frame_err_r(rx_ferr)
	);
	bdcu_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
		.clk(clk),
		.rst(rst),
		.start(tx_start_r),
		.data(tx_byte_r),
		.ready_r(tx_ready),
		.txd_r(tx_line)
	);
	// frame collection
	bdcu_state_t st_r;
	logic [7:0] frm_r [bdcu_pkg::FRAME_BYTES];
	logic [3:0] idx_r;
	logic [7:0] sum_r;
	logic [3:0] ferr_cnt_r;
	logic [7:0] err_type_r;
	logic [15:0] err_line_r;
	logic [15:0] post_r [bdcu_pkg::POST_COUNT];
	logic [7:0] rep_r [bdcu_pkg::ERR_REPLY_BYTES];
	logic [3:0] rep_len_r, rep_idx_r;
	wire logic [7:0] f_cmd = frm_r[0];
	wire logic [4:0] f_addr = frm_r[1][4:0];
	wire logic [7:0] f_reg = frm_r[2];
	wire logic [15:0] f_val = {frm_r[3], frm_r[4]};
	wire logic [15:0] f_line = {frm_r[5], frm_r[6]};
	wire logic addr_hit = (f_addr == sw_s_r) && (sw_s_r >= bdcu_pkg::ADDR_MIN)
		&& (frm_r[1][7:5] == 3'h0);
	wire logic sum_ok = (sum_r == frm_r[7]);
	wire logic is_post = (f_reg >= bdcu_pkg::REG_POST_FIRST)
		&& (f_reg <= bdcu_pkg::REG_POST_LAST);
	wire logic [3:0] post_idx = 4'(f_reg - bdcu_pkg::REG_POST_FIRST);
	// decode of a collected frame
	logic ok_write, ok_read, ok_flag, ok_fb, bad_cmd;
	always_comb begin
		ok_write = 1'b0;
		ok_read = 1'b0;
		ok_flag = 1'b0;
		ok_fb = 1'b0;
		bad_cmd = 1'b0;
		case (f_cmd)
			bdcu_pkg::CMD_WRITE: begin
				if (f_reg == bdcu_pkg::REG_DISPLAY || is_post) begin
					ok_write = 1'b1;
				end else if (f_reg == bdcu_pkg::REG_DECIMAL) begin
					ok_write = (f_val <= bdcu_pkg::DECIMAL_MAX);
					bad_cmd = !ok_write;
				end else begin
					bad_cmd = 1'b1;
				end
			end
			bdcu_pkg::CMD_READ: begin
				ok_read = is_post;
				bad_cmd = !is_post;
			end
			bdcu_pkg::CMD_FLAG_SET, bdcu_pkg::CMD_FLAG_CLR: begin
				ok_flag = (f_reg < 8'(bdcu_pkg::FLAG_COUNT));
				bad_cmd = !ok_flag;
			end
			bdcu_pkg::CMD_FEEDBACK: ok_fb = 1'b1;
			default: bad_cmd = 1'b1;
		endcase
	end
	wire logic exec_now = (st_r == BD_EXEC) && addr_hit;
	wire logic do_exec = exec_now && sum_ok && !bad_cmd;
	// main sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= BD_COLLECT;
			idx_r <= 4'h0;
			sum_r <= 8'h00;
			rep_len_r <= 4'h0;
			rep_idx_r <= 4'h0;
			tx_start_r <= 1'b0;
			tx_byte_r <= 8'h00;
			tx_en_r <= 1'b0;
			txd_r <= 1'b1;
			for (int i = 0; i < bdcu_pkg::FRAME_BYTES; i++) frm_r[i] <= 8'h00;
			for (int i = 0; i < bdcu_pkg::ERR_REPLY_BYTES; i++) rep_r[i] <= 8'h00;
		end else begin
			tx_start_r <= 1'b0;
			txd_r <= tx_line;
			case (st_r)
				BD_COLLECT: begin
					tx_en_r <= 1'b0;
					if (rx_ferr) begin
						idx_r <= 4'h0;
						sum_r <= 8'h00;
					end else if (rx_valid) begin
						frm_r[idx_r[2:0]] <= rx_data;
						idx_r <= idx_r + 4'h1;
						if (idx_r != 4'(bdcu_pkg::FRAME_BYTES - 1)) begin
							sum_r <= sum_r + rx_data;
						end else begin
							st_r <= BD_EXEC;
						end
					end
				end
				BD_EXEC: begin
					idx_r <= 4'h0;
					sum_r <= 8'h00;
					rep_idx_r <= 4'h0;
					st_r <= BD_COLLECT;
					if (addr_hit) begin
						st_r <= BD_REPLY;
						tx_en_r <= 1'b1;
						rep_len_r <= 4'h1;
						rep_r[0] <= bdcu_pkg::RSP_OK;
						if (!sum_ok || bad_cmd) begin
							rep_r[0] <= bdcu_pkg::RSP_ERROR;
						end else if (ok_read) begin
							rep_len_r <= 4'(bdcu_pkg::DATA_REPLY_BYTES);
							rep_r[0] <= bdcu_pkg::RSP_DATA;
							rep_r[1] <= post_r[post_idx][15:8];
							rep_r[2] <= post_r[post_idx][7:0];
							rep_r[3] <= bdcu_pkg::RSP_DATA ^ post_r[post_idx][15:8]
								^ post_r[post_idx][7:0];
						end else if (ok_fb) begin
							rep_len_r <= 4'(bdcu_pkg::ERR_REPLY_BYTES);
							rep_r[0] <= bdcu_pkg::ERR_PREFIX;
							rep_r[1] <= bdcu_pkg::ERR_PREFIX;
							rep_r[2] <= err_type_r;
							rep_r[3] <= bdcu_pkg::ASCII_DOT;
							rep_r[4] <= {3'h0, sw_s_r};
							rep_r[5] <= bdcu_pkg::ASCII_DOT;
							rep_r[6] <= err_line_r[15:8];
							rep_r[7] <= err_line_r[7:0];
							rep_r[8] <= bdcu_pkg::RSP_DATA;
							rep_r[9] <= err_type_r + {3'h0, sw_s_r} + err_line_r[15:8]
								+ err_line_r[7:0];
						end
					end
				end
				BD_REPLY: begin
					if (tx_ready && !tx_start_r) begin
						if (rep_idx_r == rep_len_r) begin
							st_r <= BD_WAIT;
						end else begin
							tx_byte_r <= rep_r[rep_idx_r];
							tx_start_r <= 1'b1;
							rep_idx_r <= rep_idx_r + 4'h1;
						end
					end
				end
				BD_WAIT: begin
					if (tx_ready && !tx_start_r) begin
						tx_en_r <= 1'b0;
						st_r <= BD_COLLECT;
					end
				end
				default: st_r <= BD_COLLECT;
			endcase
		end
	end
	// error record; checksum and command faults overwrite type and line, every third framing fault the type only; feedback reads without clearing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_type_r <= bdcu_pkg::ERR_NONE;
			err_line_r <= 16'h0000;
			ferr_cnt_r <= 4'h0;
		end else begin
			if (rx_ferr) begin
				if (ferr_cnt_r + 4'h1 >= bdcu_pkg::FRAME_ERR_LIMIT) begin
					err_type_r <= bdcu_pkg::ERR_FRAMING;
					ferr_cnt_r <= 4'h0;
				end else begin
					ferr_cnt_r <= ferr_cnt_r + 4'h1;
				end
			end else if (rx_valid && st_r == BD_COLLECT && idx_r == 4'h0) begin
				ferr_cnt_r <= 4'h0;
			end
			if (exec_now && !sum_ok) begin
				err_type_r <= bdcu_pkg::ERR_CHECKSUM;
				err_line_r <= f_line;
			end else if (exec_now && bad_cmd) begin
				err_type_r <= bdcu_pkg::ERR_COMMAND;
				err_line_r <= f_line;
			end
		end
	end
	// display and decimal registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			display_value_r <= bdcu_pkg::VALUE_RESET;
			decimal_places_r <= bdcu_pkg::DECIMAL_RESET[2:0];
		end else if (do_exec && ok_write) begin
			if (f_reg == bdcu_pkg::REG_DISPLAY) display_value_r <= f_val;
			if (f_reg == bdcu_pkg::REG_DECIMAL) decimal_places_r <= f_val[2:0];
		end
	end
	// postboxes, one per entry
	for (genvar g = 0; g < bdcu_pkg::POST_COUNT; g++) begin : g_post
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				post_r[g] <= bdcu_pkg::VALUE_RESET;
			end else if (do_exec && ok_write && is_post && post_idx == 4'(g)) begin
				post_r[g] <= f_val;
			end
		end
	end
	// flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_r <= bdcu_pkg::FLAG_RESET;
		end else if (do_exec && ok_flag) begin
			flags_r[f_reg[4:0]] <= (f_cmd == bdcu_pkg::CMD_FLAG_SET);
		end
	end
	chk_decimal_range: assert property (@(posedge clk) disable iff (rst)
		decimal_places_r <= bdcu_pkg::DECIMAL_MAX[2:0]) else $error("decimal out of range");
	chk_bad_no_write: assert property (@(posedge clk) disable iff (rst)
		exec_now && bad_cmd |=> $stable(display_value_r) && $stable(decimal_places_r))
		else $error("bad command changed display");
	chk_cksum_err_type: assert property (@(posedge clk) disable iff (rst)
		exec_now && !sum_ok |=> err_type_r == bdcu_pkg::ERR_CHECKSUM)
		else $error("checksum error not recorded");
	chk_bad_cmd_type: assert property (@(posedge clk) disable iff (rst)
		exec_now && sum_ok && bad_cmd |=> err_type_r == bdcu_pkg::ERR_COMMAND)
		else $error("command error not recorded");
	chk_write_display: assert property (@(posedge clk) disable iff (rst)
		do_exec && ok_write && f_reg == bdcu_pkg::REG_DISPLAY |=> display_value_r == $past(f_val))
		else $error("display not loaded");
	chk_foreign_silent: assert property (@(posedge clk) disable iff (rst)
		st_r == BD_EXEC && !addr_hit |=> !tx_en_r && st_r == BD_COLLECT)
		else $error("answered foreign address");
	chk_error_reply: assert property (@(posedge clk) disable iff (rst)
		exec_now && (bad_cmd || !sum_ok) |=> rep_r[0] == bdcu_pkg::RSP_ERROR && rep_len_r == 4'h1)
		else $error("error reply missing");
	chk_feedback_fmt: assert property (@(posedge clk) disable iff (rst)
		do_exec && ok_fb |=> rep_r[0] == bdcu_pkg::ERR_PREFIX && rep_r[3] == bdcu_pkg::ASCII_DOT
		&& rep_r[2] == $past(err_type_r)) else $error("report format wrong");
	chk_reply_enable: assert property (@(posedge clk) disable iff (rst)
		st_r == BD_REPLY |-> tx_en_r) else $error("driver off during reply");
	cov_write_display: cover property (@(posedge clk) disable iff (rst)
		do_exec && ok_write && f_reg == bdcu_pkg::REG_DISPLAY);
	cov_feedback: cover property (@(posedge clk) disable iff (rst) do_exec && ok_fb);
	cov_cksum_fault: cover property (@(posedge clk) disable iff (rst) exec_now && !sum_ok);
	cov_framing: cover property (@(posedge clk) disable iff (rst)
		err_type_r == bdcu_pkg::ERR_FRAMING);
endmodule

// file: verif/bdcu_ctrl_model.sv
// bdcu_ctrl_model: motion controller on the far side of the serial bus.
// assumes it alone drives rxd and listens on txd_r while tx_en_r is high.
`timescale 1ns/1ps
module bdcu_ctrl_model #(
	parameter int BIT_CYC = 8
) (
	// clock
	input wire logic clk,
	// line
	output logic rxd,
	input wire logic txd_r,
	input wire logic tx_en_r
);
	logic [7:0] rx_byte;
	logic rx_stop;
	event byte_ev;
	// released line rests high, as the bus bias does
	initial rxd = 1'b1;
	// one 8N1 character, lsb first; stop_bit low makes a framing fault
	task automatic send_byte(input logic [7:0] b, input logic stop_bit);
		rxd = 1'b0;
		repeat (BIT_CYC) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			rxd = b[i];
			repeat (BIT_CYC) @(negedge clk);
		end
		rxd = stop_bit;
		repeat (BIT_CYC) @(negedge clk);
		// spoiled stop bit: back to idle for one edge before any next start
		if (!stop_bit) begin
			rxd = 1'b1;
			@(negedge clk);
		end
	endtask
	// whole frame, fields hi byte first, additive checksum; bad_ck spoils it
	task automatic send_frame(input logic [7:0] cmd, input logic [4:0] a, input logic [7:0] rg,
		input logic [15:0] val, input logic [15:0] ln, input logic bad_ck);
		logic [7:0] f [8];
		logic [7:0] ck;
		f = '{cmd, {3'h0, a}, rg, val[15:8], val[7:0], ln[15:8], ln[7:0], 8'h00};
		ck = 8'h00;
		for (int i = 0; i < 7; i++) ck = ck + f[i];
		f[7] = ck + {7'h00, bad_ck};
		@(negedge clk);
		for (int i = 0; i < 8; i++) send_byte(f[i], 1'b1);
	endtask
	// listen only while the driver is on; the wire is not the device's otherwise
	always begin
		@(posedge clk iff (tx_en_r === 1'b1 && txd_r === 1'b0));
		repeat (BIT_CYC / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk);
			rx_byte[i] = txd_r;
		end
		repeat (BIT_CYC) @(posedge clk);
		rx_stop = txd_r;
		-> byte_ev;
	end
endmodule

// file: verif/bdcu_top_bench.sv
// bdcu_top_bench: self-checking bench of the command unit.
// assumes the controller model owns rxd; BIT_CYC shortened to 8 for run time.
`timescale 1ns/1ps
module bdcu_top_bench;
	localparam int BC = 8;
	localparam logic [4:0] MY_ADDR = 5'h09;
	logic clk, rst, rxd, txd_r, tx_en_r;
	logic [4:0] addr_sw;
	logic [15:0] display_value_r;
	logic [2:0] decimal_places_r;
	logic [31:0] flags_r, flg, seed;
	logic [15:0] v, ln, err_ln;
	logic [15:0] pv [2];
	logic [7:0] err_t;
	logic [7:0] exp_q [$];
	int fail_count, num_checks;

	bdcu_top #(.BIT_CYC(BC)) dut_u (.clk(clk), .rst(rst), .rxd(rxd), .txd_r(txd_r),
		.tx_en_r(tx_en_r), .addr_sw(addr_sw), .display_value_r(display_value_r),
		.decimal_places_r(decimal_places_r), .flags_r(flags_r));
	bdcu_ctrl_model #(.BIT_CYC(BC)) ctrl_u (.clk(clk), .rxd(rxd), .txd_r(txd_r),
		.tx_en_r(tx_en_r));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task automatic rnd16(output logic [15:0] r);
		seed = xs(seed);
		r = seed[15:0];
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic timeout;
		fail_count++;
		$display("wrong value at %0t: wait ran out", $time);
		end_sim();
	endtask
	// every reply byte takes the oldest note; a byte with no note is a fault
	always begin
		@(ctrl_u.byte_ev);
		check({31'h0, ctrl_u.rx_stop}, 32'h1);
		if (exp_q.size() == 0) begin
			fail_count++;
			$display("wrong value at %0t: reply byte not expected", $time);
		end else check(ctrl_u.rx_byte, exp_q.pop_front());
	end
	// one frame, then the whole reply; other addresses must stay silent
	task automatic xfer(input logic [7:0] cmd, input logic [4:0] a, input logic [7:0] rg,
		input logic [15:0] val, input logic bad_ck);
		int n;
		rnd16(ln);
		ctrl_u.send_frame(cmd, a, rg, val, ln, bad_ck);
		n = 0;
		while (tx_en_r !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (a != MY_ADDR) check({31'h0, tx_en_r}, 32'h0);
		else begin
			if (n == 40) timeout();
			n = 0;
			while (tx_en_r !== 1'b0 && n < 1000) begin
				@(negedge clk);
				n++;
			end
			if (n == 1000) timeout();
			repeat (6) @(negedge clk);
		end
	endtask
	task automatic ok(input logic [7:0] cmd, input logic [7:0] rg, input logic [15:0] val);
		exp_q.push_back(bdcu_pkg::RSP_OK);
		xfer(cmd, MY_ADDR, rg, val, 1'b0);
	endtask
	// query after a halt: prefix, type, address, line; type, address and line dot separated
	task automatic feedback;
		logic [7:0] a;
		a = {3'h0, MY_ADDR};
		exp_q = {exp_q, bdcu_pkg::ERR_PREFIX, bdcu_pkg::ERR_PREFIX, err_t, bdcu_pkg::ASCII_DOT, a,
			bdcu_pkg::ASCII_DOT, err_ln[15:8], err_ln[7:0], bdcu_pkg::RSP_DATA,
			8'(err_t + a + err_ln[15:8] + err_ln[7:0])};
		xfer(bdcu_pkg::CMD_FEEDBACK, MY_ADDR, 8'h00, 16'h0000, 1'b0);
	endtask
	task automatic bad(input logic [7:0] cmd, input logic [7:0] rg, input logic [15:0] val,
		input logic bad_ck, input logic [7:0] t);
		exp_q.push_back(bdcu_pkg::RSP_ERROR);
		xfer(cmd, MY_ADDR, rg, val, bad_ck);
		err_t = t;
		err_ln = ln;
		feedback();
		check(display_value_r, v);
	endtask

	initial begin
		rst = 1'b1;
		addr_sw = MY_ADDR;
		seed = 32'h0001_0AD7;
		fail_count = 0;
		num_checks = 0;
		flg = bdcu_pkg::FLAG_RESET;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		check(display_value_r, 32'h0);
		check(decimal_places_r, 32'h0);
		check(flags_r, flg);
		for (int i = 0; i < 3; i++) begin
			rnd16(v);
			ok(bdcu_pkg::CMD_WRITE, bdcu_pkg::REG_DISPLAY, v);
			check(display_value_r, v);
		end
		ok(bdcu_pkg::CMD_WRITE, bdcu_pkg::REG_DECIMAL, 16'h0005);
		check(decimal_places_r, 32'h5);
		ok(bdcu_pkg::CMD_WRITE, bdcu_pkg::REG_DECIMAL, 16'h0000);
		check(decimal_places_r, 32'h0);
		bad(bdcu_pkg::CMD_WRITE, bdcu_pkg::REG_DECIMAL, 16'h0006, 1'b0, bdcu_pkg::ERR_COMMAND);
		check(decimal_places_r, 32'h0);
		// both ends written before either is read, so storage must be distinct
		for (int i = 0; i < 2; i++) begin
			rnd16(pv[i]);
			ok(bdcu_pkg::CMD_WRITE, i ? bdcu_pkg::REG_POST_LAST : bdcu_pkg::REG_POST_FIRST, pv[i]);
		end
		for (int i = 0; i < 2; i++) begin
			exp_q = {exp_q, bdcu_pkg::RSP_DATA, pv[i][15:8], pv[i][7:0],
				bdcu_pkg::RSP_DATA ^ pv[i][15:8] ^ pv[i][7:0]};
			xfer(bdcu_pkg::CMD_READ, MY_ADDR, i ? bdcu_pkg::REG_POST_LAST : bdcu_pkg::REG_POST_FIRST,
				16'h0000, 1'b0);
			check(display_value_r, v);
		end
		bad(bdcu_pkg::CMD_WRITE, 8'h02, v, 1'b0, bdcu_pkg::ERR_COMMAND);
		bad(bdcu_pkg::CMD_READ, bdcu_pkg::REG_DISPLAY, 16'h0000, 1'b0, bdcu_pkg::ERR_COMMAND);
		bad(bdcu_pkg::CMD_FLAG_SET, 8'h20, 16'h0020, 1'b0, bdcu_pkg::ERR_COMMAND);
		bad(8'h55, bdcu_pkg::REG_DISPLAY, 16'h0000, 1'b0, bdcu_pkg::ERR_COMMAND);
		bad(bdcu_pkg::CMD_WRITE, bdcu_pkg::REG_DISPLAY, ~v, 1'b1, bdcu_pkg::ERR_CHECKSUM);
		// three framing faults; the recorded line stays that of the earlier checksum fault
		repeat (3) begin
			ctrl_u.send_byte(bdcu_pkg::CMD_WRITE, 1'b0);
			repeat (2 * BC) @(negedge clk);
			check({31'h0, tx_en_r}, 32'h0);
		end
		err_t = bdcu_pkg::ERR_FRAMING;
		feedback();
		ok(bdcu_pkg::CMD_FLAG_SET, 8'h03, 16'h0003);
		flg[3] = 1'b1;
		check(flags_r, flg);
		ok(bdcu_pkg::CMD_FLAG_CLR, 8'h07, 16'h0007);
		flg[7] = 1'b0;
		check(flags_r, flg);
		xfer(bdcu_pkg::CMD_WRITE, 5'h0A, bdcu_pkg::REG_DISPLAY, ~v, 1'b0);
		check(display_value_r, v);
		// switches at zero: the unit answers nobody
		addr_sw = 5'h00;
		repeat (3) @(negedge clk);
		xfer(bdcu_pkg::CMD_WRITE, 5'h00, bdcu_pkg::REG_DISPLAY, ~v, 1'b0);
		check(display_value_r, v);
		check(exp_q.size(), 32'h0);
		end_sim();
	end
endmodule
